// >>> pcr_config_header_regs.v
`timescale 1ns/1ps
`include "pcr_defs.vh"

// Functional notes
// [R1] I/O BAR base bits 31:8, 256-byte window
// [R2] I/O BAR bit0 reads one, 7:1 reserved
// [R3] Same storage appears at config offset 0x24
// [R4] Subsystem ids read-only, zero reset, EEPROM-loadable
// [R5] Capability pointer fixed 0xDC, upper reserved
// [R6] Max latency resets 0x0A, 250ns units
// [R7] Min grant resets 0x02, 250ns units
// [R8] Interrupt pin resets 0x01, 00h-04h valid
// [R9] Latency, grant, pin changed only by EEPROM
// [R10] Interrupt line read/write, zero reset, unused
// [R11] Board routes interrupt pin via EEPROM
// [R12] Reserved and read-only bits ignore writes
module pcr_config_header_regs (
   input wire sys_clk,
   input wire nrst,
   input wire clk_en,
   input wire loc_sel,
   input wire loc_wr,
   input wire [15:0] loc_addr,
   input wire [31:0] loc_wdata,
   input wire [3:0] loc_be,
   output wire [31:0] loc_rdata,
   output wire loc_ack,
   input wire cfg_sel,
   input wire cfg_wr,
   input wire [7:0] cfg_addr,
   input wire [31:0] cfg_wdata,
   input wire [3:0] cfg_be,
   output wire [31:0] cfg_rdata,
   output wire cfg_ack,
   input wire ee_load,
   input wire [1:0] ee_sel,
   input wire [31:0] ee_data,
   input wire io_cyc,
   input wire [31:0] io_addr,
   output wire io_hit
);

   // Registered outputs; every output port is driven straight from one of these
   reg [31:0] loc_rdata_reg;
   reg loc_ack_reg;
   reg [31:0] cfg_rdata_reg;
   reg cfg_ack_reg;
   reg io_hit_reg;

   // Stored configuration fields
   reg [23:0] iobase_reg;
   reg [31:0] subsys_reg;
   reg [7:0] max_latency_field_reg;
   reg [7:0] min_grant_field_reg;
   reg [7:0] interrupt_pin_select_reg;
   reg [7:0] interrupt_line_byte_reg;

   // Next values
   wire [23:0] iobase_next;
   reg [31:0] subsys_next;
   reg [7:0] max_latency_field_next;
   reg [7:0] min_grant_field_next;
   reg [7:0] interrupt_pin_select_next;
   reg [7:0] interrupt_line_byte_next;
   reg [31:0] loc_rdata_next;
   reg [31:0] cfg_rdata_next;
   reg io_hit_next;

   // Offset decode for the two access ports
   wire loc_io = loc_addr == `PCR_OFF_IOBASE;
   wire loc_cfg2 = loc_addr == `PCR_OFF_CFG2;
   wire cfg_io = cfg_addr == `PCR_CFG_IOBASE;
   wire cfg_cfg2 = cfg_addr == `PCR_CFG_CFG2;

   // Both ports reach one storage; the local port wins a same-cycle write collision
   wire loc_write = loc_sel & loc_wr;
   wire cfg_write = cfg_sel & cfg_wr & ~loc_write;
   wire loc_read = loc_sel & ~loc_wr;
   wire cfg_read = cfg_sel & ~cfg_wr;
   wire io_wr = (loc_write & loc_io) | (cfg_write & cfg_io); // see [R3]
   wire il_wr = (loc_write & loc_cfg2) | (cfg_write & cfg_cfg2);
   wire [31:0] wd = loc_write ? loc_wdata : cfg_wdata;
   wire [3:0] wbe = loc_write ? loc_be : cfg_be;

   // EEPROM load groups; the other selector codes are ignored
   wire ee_subsys = ee_load & (ee_sel == `PCR_LD_SUBSYS);
   wire ee_cfg2 = ee_load & (ee_sel == `PCR_LD_CFG2);

   // Upper address bits of an I/O cycle, compared against the stored base
   wire [23:0] io_page = io_addr[`PCR_IOBASE_MSB:`PCR_IOBASE_LSB];
   wire io_page_match = io_page == iobase_reg;

   wire [31:0] io_word = {iobase_reg, `PCR_IO_RSVD_VAL, `PCR_IO_FLAG_VAL}; // see [R2]
   wire [31:0] cap_word = {`PCR_CAP_RSVD_VAL, `PCR_CAPABILITY_LIST_OFFSET_VAL}; // see [R5]
   wire [31:0] cfg2_word = {max_latency_field_reg, min_grant_field_reg,
                            interrupt_pin_select_reg, interrupt_line_byte_reg};

   reg [31:0] loc_mux;
   reg [31:0] cfg_mux;

   always @* begin
      case (loc_addr)
         `PCR_OFF_IOBASE: loc_mux = io_word;
         `PCR_OFF_SUBSYS: loc_mux = subsys_reg;
         `PCR_OFF_CAPABILITY_LIST_OFFSET: loc_mux = cap_word;
         `PCR_OFF_CFG2: loc_mux = cfg2_word;
         default: loc_mux = `PCR_UNMAPPED_VAL;
      endcase
   end

   always @* begin
      case (cfg_addr)
         `PCR_CFG_IOBASE: cfg_mux = io_word; // see [R3]
         `PCR_CFG_SUBSYS: cfg_mux = subsys_reg;
         `PCR_CFG_CAPABILITY_LIST_OFFSET: cfg_mux = cap_word;
         `PCR_CFG_CFG2: cfg_mux = cfg2_word;
         default: cfg_mux = `PCR_UNMAPPED_VAL;
      endcase
   end

   // One lane per stored base byte; the low byte of the BAR has no storage
   genvar lane;
   generate
      for (lane = 0; lane < `PCR_IOBASE_LANES; lane = lane + 1) begin : g_base_lane
         wire lane_wr = io_wr & wbe[lane + `PCR_IOBASE_BE_LO]; // see [R1] [R12]
         assign iobase_next[lane*8 +: 8] = lane_wr ? wd[lane*8 + `PCR_IOBASE_LSB +: 8] :
                                                     iobase_reg[lane*8 +: 8];
      end
   endgenerate

   // Subsystem word is read-only to both ports
   always @* begin
      subsys_next = subsys_reg;
      if (ee_subsys) begin
         subsys_next = ee_data; // see [R4] [R12]
      end
   end

   // Latency, grant and pin ignore bus writes; only the EEPROM load moves them
   always @* begin
      max_latency_field_next = max_latency_field_reg;
      min_grant_field_next = min_grant_field_reg;
      interrupt_pin_select_next = interrupt_pin_select_reg;
      if (ee_cfg2) begin
         max_latency_field_next = ee_data[`PCR_MAXLAT_LSB +: 8]; // see [R9] [R6]
         min_grant_field_next = ee_data[`PCR_MINGNT_LSB +: 8]; // see [R9] [R7]
         interrupt_pin_select_next = ee_data[`PCR_INTPIN_LSB +: 8]; // see [R9] [R8]
      end
   end

   // Interrupt line is bookkeeping only; nothing in the block acts on it
   always @* begin
      interrupt_line_byte_next = interrupt_line_byte_reg;
      if (il_wr && wbe[`PCR_INTLINE_BE]) begin
         interrupt_line_byte_next = wd[`PCR_INTLINE_LSB +: 8]; // see [R10]
      end
   end

   // Read data is zero outside reads so a write never echoes stale data
   always @* begin
      loc_rdata_next = `PCR_UNMAPPED_VAL;
      if (loc_read) begin
         loc_rdata_next = loc_mux; // see [R12]
      end
   end

   always @* begin
      cfg_rdata_next = `PCR_UNMAPPED_VAL;
      if (cfg_read) begin
         cfg_rdata_next = cfg_mux; // see [R3] [R12]
      end
   end

   // Claim decode uses the stored base; a new base claims from the next cycle on
   always @* begin
      io_hit_next = 1'b0;
      if (io_cyc && io_page_match) begin
         io_hit_next = 1'b1; // see [R1]
      end
   end

   // Reset wins over the clock enable so a stalled enable cannot block initialisation
   always @(posedge sys_clk) begin
      if (!nrst) begin
         iobase_reg <= `PCR_IOBASE_RST;
         subsys_reg <= `PCR_SUBSYS_RST; // see [R4]
         max_latency_field_reg <= `PCR_MAXLAT_RST; // see [R6]
         min_grant_field_reg <= `PCR_MINGNT_RST; // see [R7]
         interrupt_pin_select_reg <= `PCR_INTPIN_RST; // see [R8]
         interrupt_line_byte_reg <= `PCR_INTLINE_RST; // see [R10]
      end else if (clk_en) begin
         iobase_reg <= iobase_next;
         subsys_reg <= subsys_next;
         max_latency_field_reg <= max_latency_field_next;
         min_grant_field_reg <= min_grant_field_next;
         interrupt_pin_select_reg <= interrupt_pin_select_next;
         interrupt_line_byte_reg <= interrupt_line_byte_next;
      end
   end

   // Output stage; acknowledges are one-cycle pulses per selected cycle
   always @(posedge sys_clk) begin
      if (!nrst) begin
         loc_rdata_reg <= `PCR_UNMAPPED_VAL;
         loc_ack_reg <= 1'b0;
         cfg_rdata_reg <= `PCR_UNMAPPED_VAL;
         cfg_ack_reg <= 1'b0;
         io_hit_reg <= 1'b0;
      end else if (clk_en) begin
         loc_rdata_reg <= loc_rdata_next;
         loc_ack_reg <= loc_sel;
         cfg_rdata_reg <= cfg_rdata_next;
         cfg_ack_reg <= cfg_sel;
         io_hit_reg <= io_hit_next;
      end
   end

   assign loc_rdata = loc_rdata_reg;
   assign loc_ack = loc_ack_reg;
   assign cfg_rdata = cfg_rdata_reg;
   assign cfg_ack = cfg_ack_reg;
   assign io_hit = io_hit_reg;

endmodule // pcr_config_header_regs

// >>> pcr_defs.vh
`ifndef PCR_DEFS_VH
`define PCR_DEFS_VH
// Local register offsets (low 16 bits of the internal address)
`define PCR_OFF_IOBASE 16'hd024
`define PCR_OFF_SUBSYS 16'hd02c
`define PCR_OFF_CAPABILITY_LIST_OFFSET 16'hd034
`define PCR_OFF_CFG2 16'hd03c
// Configuration space offsets (dword aligned)
`define PCR_CFG_IOBASE 8'h24
`define PCR_CFG_SUBSYS 8'h2c
`define PCR_CFG_CAPABILITY_LIST_OFFSET 8'h34
`define PCR_CFG_CFG2 8'h3c
// Field positions
`define PCR_IOBASE_MSB 31
`define PCR_IOBASE_LSB 8
`define PCR_IO_FLAG_BIT 0
`define PCR_IOBASE_LANES 3
`define PCR_IOBASE_BE_LO 1
`define PCR_MAXLAT_LSB 24
`define PCR_MINGNT_LSB 16
`define PCR_INTPIN_LSB 8
`define PCR_INTLINE_LSB 0
`define PCR_INTLINE_BE 0
// Reset and fixed values
`define PCR_IOBASE_RST 24'h00_0000
`define PCR_IO_RSVD_VAL 7'h00
`define PCR_CAP_RSVD_VAL 24'h00_0000
`define PCR_UNMAPPED_VAL 32'h0000_0000
`define PCR_IO_FLAG_VAL 1'h1
`define PCR_SUBSYS_RST 32'h0000_0000
`define PCR_CAPABILITY_LIST_OFFSET_VAL 8'hdc
`define PCR_MAXLAT_RST 8'h0a
`define PCR_MINGNT_RST 8'h02
`define PCR_INTPIN_RST 8'h01
`define PCR_INTLINE_RST 8'h00
// EEPROM load selectors
`define PCR_LD_SUBSYS 2'h0
`define PCR_LD_CFG2 2'h1
`endif

// >>> pcr_properties.sv
`timescale 1ns/1ps
module pcr_props (
   input wire sys_clk,
   input wire nrst,
   input wire clk_en,
   input wire loc_sel,
   input wire loc_wr,
   input wire loc_ack,
   input wire cfg_sel,
   input wire cfg_wr,
   input wire cfg_ack,
   input wire io_cyc,
   input wire io_hit,
   input wire [15:0] loc_addr,
   input wire [7:0] cfg_addr,
   input wire [31:0] loc_rdata,
   input wire [31:0] cfg_rdata
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   wire lrd = loc_sel & ~loc_wr & clk_en;
   wire crd = cfg_sel & ~cfg_wr & clk_en;
   wire lwr = loc_sel & loc_wr & clk_en;
   a_bar_flag:
      assert property (lrd && loc_addr == 16'hd024 |=> loc_rdata[7:0] == 8'h01) else $error("flag");
   a_cap_local:
      assert property (lrd && loc_addr == 16'hd034 |=> loc_rdata == 32'h0000_00dc) else $error("cap");
   a_cap_config:
      assert property (crd && cfg_addr == 8'h34 |=> cfg_rdata == 32'h0000_00dc) else $error("cap");
   a_bar_mirror:
      assert property (crd && cfg_addr == 8'h24 |=> cfg_ack && cfg_rdata[0]) else $error("mirror");
   a_unmapped_zero:
      assert property (lrd && loc_addr == 16'hd030 |=> loc_rdata == 0) else $error("unmapped");
   a_cfg_unmapped:
      assert property (crd && cfg_addr == 8'h30 |=> cfg_rdata == 0) else $error("cfg unmapped");
   a_write_quiet:
      assert property (lwr |=> loc_ack && loc_rdata == 0) else $error("write data");
   a_pin_valid:
      assert property (lrd && loc_addr == 16'hd03c |=> loc_rdata[15:8] <= 8'h04) else $error("pin");
   a_hit_cause:
      assert property (io_hit && $past(clk_en) |-> $past(io_cyc)) else $error("hit");
   a_idle_nohit:
      assert property (!io_cyc && clk_en |=> !io_hit) else $error("idle hit");
endmodule // pcr_props
bind pcr_config_header_regs pcr_props pcr_props_i (
   .sys_clk(sys_clk),
   .nrst(nrst),
   .clk_en(clk_en),
   .loc_sel(loc_sel),
   .loc_wr(loc_wr),
   .loc_ack(loc_ack),
   .cfg_sel(cfg_sel),
   .cfg_wr(cfg_wr),
   .cfg_ack(cfg_ack),
   .io_cyc(io_cyc),
   .io_hit(io_hit),
   .loc_addr(loc_addr),
   .cfg_addr(cfg_addr),
   .loc_rdata(loc_rdata),
   .cfg_rdata(cfg_rdata)
);

// >>> pcr_host_model.sv
`timescale 1ns/1ps
module pcr_host_model (
   input wire sys_clk,
   input wire cfg_ack,
   input wire [31:0] cfg_rdata,
   output reg cfg_sel = 0,
   output reg cfg_wr = 0,
   output reg [7:0] cfg_addr = 0,
   output reg [31:0] cfg_wdata = 0,
   output reg [3:0] cfg_be = 0
);
   // Released after one taken edge; holding longer would issue a second request
   task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] r, output k);
      @(negedge sys_clk);
      {cfg_sel, cfg_wr, cfg_addr, cfg_wdata, cfg_be} = {1'b1, w, a, d, 4'hf};
      @(negedge sys_clk);
      r = cfg_rdata;
      k = cfg_ack;
      cfg_sel = 0;
      cfg_wdata = ~d;
   endtask
endmodule // pcr_host_model

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
   reg sys_clk = 0, nrst = 0, clk_en = 1, loc_sel = 0, loc_wr = 0, ee_load = 0, io_cyc = 0, k;
   reg [1:0] ee_sel = 0;
   reg [3:0] loc_be = 0;
   reg [15:0] loc_addr = 0;
   reg [31:0] loc_wdata = 0, ee_data = 0, io_addr = 0, r;
   wire loc_ack, cfg_ack, cfg_sel, cfg_wr, io_hit;
   wire [3:0] cfg_be;
   wire [7:0] cfg_addr;
   wire [31:0] loc_rdata, cfg_rdata, cfg_wdata;
   integer errors = 0, compares = 0;
   always #2 sys_clk = ~sys_clk;
   pcr_config_header_regs pcr_config_header_regs_i (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .clk_en(clk_en),
      .loc_sel(loc_sel),
      .loc_wr(loc_wr),
      .loc_addr(loc_addr),
      .loc_wdata(loc_wdata),
      .loc_be(loc_be),
      .loc_rdata(loc_rdata),
      .loc_ack(loc_ack),
      .cfg_sel(cfg_sel),
      .cfg_wr(cfg_wr),
      .cfg_addr(cfg_addr),
      .cfg_wdata(cfg_wdata),
      .cfg_be(cfg_be),
      .cfg_rdata(cfg_rdata),
      .cfg_ack(cfg_ack),
      .ee_load(ee_load),
      .ee_sel(ee_sel),
      .ee_data(ee_data),
      .io_cyc(io_cyc),
      .io_addr(io_addr),
      .io_hit(io_hit)
   );
   pcr_host_model pcr_host_model_i (
      .sys_clk(sys_clk),
      .cfg_ack(cfg_ack),
      .cfg_rdata(cfg_rdata),
      .cfg_sel(cfg_sel),
      .cfg_wr(cfg_wr),
      .cfg_addr(cfg_addr),
      .cfg_wdata(cfg_wdata),
      .cfg_be(cfg_be)
   );
   task chk(input [31:0] g, e);
      compares = compares + 1;
      if (g !== e) begin
         errors = errors + 1;
         $display("Error %0t: got %h want %h", $time, g, e);
      end
   endtask
   task lc(input w, input [15:0] a, input [31:0] d, input [3:0] b, input [31:0] e);
      @(negedge sys_clk);
      {loc_sel, loc_wr, loc_addr, loc_wdata, loc_be} = {1'b1, w, a, d, b};
      @(negedge sys_clk);
      chk(loc_ack, 1);
      chk(loc_rdata, e);
      loc_sel = 0;
      loc_wdata = ~d;
   endtask
   task cf(input w, input [7:0] a, input [31:0] d, e);
      pcr_host_model_i.xfer(w, a, d, r, k);
      chk(k, 1);
      chk(r, e);
   endtask
   task ee(input [1:0] s, input [31:0] d);
      @(negedge sys_clk);
      {ee_load, ee_sel, ee_data} = {1'b1, s, d};
      @(negedge sys_clk);
      ee_load = 0;
   endtask
   task io(input [31:0] a, input h);
      @(negedge sys_clk);
      {io_cyc, io_addr} = {1'b1, a};
      @(negedge sys_clk);
      chk(io_hit, h);
      io_cyc = 0;
   endtask
   task results;
      if (errors == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (3) @(negedge sys_clk);
      nrst = 1;
      lc(0, 16'hd024, 0, 0, 32'h0000_0001);
      lc(0, 16'hd02c, 0, 0, 0);
      lc(0, 16'hd034, 0, 0, 32'h0000_00dc);
      lc(0, 16'hd03c, 0, 0, 32'h0a02_0100);
      lc(1, 16'hd024, 32'hffff_ffff, 4'hf, 0);
      lc(0, 16'hd024, 0, 0, 32'hffff_ff01);
      cf(1, 8'h24, 32'h1234_56ff, 0);
      lc(0, 16'hd024, 0, 0, 32'h1234_5601);
      io(32'h1234_5600, 1);
      io(32'h1234_56ff, 1);
      io(32'h1234_5700, 0);
      lc(1, 16'hd034, 32'hffff_ffff, 4'hf, 0);
      cf(0, 8'h34, 0, 32'h0000_00dc);
      lc(1, 16'hd02c, 32'hffff_ffff, 4'hf, 0);
      cf(0, 8'h2c, 0, 0);
      lc(1, 16'hd03c, 32'h5555_55a5, 4'hf, 0);
      cf(0, 8'h3c, 0, 32'h0a02_01a5);
      ee(0, 32'h1234_5678);
      cf(0, 8'h2c, 0, 32'h1234_5678);
      ee(1, 32'hff03_04ee);
      ee(2, 0);
      lc(0, 16'hd03c, 0, 0, 32'hff03_04a5);
      lc(0, 16'hd030, 0, 0, 0);
      lc(1, 16'hd024, 32'haabb_ccdd, 4'h4, 0);
      lc(0, 16'hd024, 0, 0, 32'h12bb_5601);
      cf(0, 8'h24, 0, 32'h12bb_5601);
      cf(0, 8'h30, 0, 0);
      lc(1, 16'hd03c, 32'h0000_0077, 4'he, 0);
      cf(1, 8'h3c, 32'h0000_005a, 0);
      lc(0, 16'hd03c, 0, 0, 32'hff03_045a);
      fork
         lc(1, 16'hd03c, 32'h0000_0011, 4'hf, 0);
         cf(1, 8'h3c, 32'h0000_0022, 0);
      join
      lc(0, 16'hd03c, 0, 0, 32'hff03_0411);
      @(negedge sys_clk);
      clk_en = 0;
      {loc_sel, loc_wr, loc_addr, loc_wdata, loc_be} = {2'b11, 16'hd03c, 32'h0000_0033, 4'hf};
      repeat (2) @(negedge sys_clk);
      chk(loc_ack, 0);
      loc_sel = 0;
      clk_en = 1;
      lc(0, 16'hd03c, 0, 0, 32'hff03_0411);
      @(negedge sys_clk);
      nrst = 0;
      repeat (3) @(negedge sys_clk);
      nrst = 1;
      lc(0, 16'hd03c, 0, 0, 32'h0a02_0100);
      cf(0, 8'h2c, 0, 0);
      lc(0, 16'hd024, 0, 0, 32'h0000_0001);
      results;
   end
endmodule // tb_top
